// file: src/mebm_map.svh
/*
 * Named constants of the external bus and boot-mode block.
 * Assumes one core_clk edge per crystal clock.
 */
`ifndef MEBM_MAP_SVH
`define MEBM_MAP_SVH

// phase counter: twelve phases per machine cycle, two halves of six
`define MEBM_PH_MC      5'h0C
`define MEBM_PH_HALF    5'h06
`define MEBM_HALF_OFS   4'h6
`define MEBM_PH_ZERO    4'h0
`define MEBM_STEP_STD   5'h01
`define MEBM_STEP_FAST  5'h02
`define MEBM_ALE_LEN    4'h2

// reset pin counts, in machine cycles
`define MEBM_CNT_ZERO   5'h00
`define MEBM_CNT_ONE    5'h01
`define MEBM_RST_MC     5'h02
`define MEBM_HOST_MC    5'h14
`define MEBM_CNT_SAT    5'h15

`define MEBM_BYTE_ZERO  8'h00
`define MEBM_BYTE_ONES  8'hFF
`define MEBM_NIB_ONES   4'hF

`endif

// file: src/mebm_pkg.sv
/*
 * Types of the external bus and boot-mode block.
 * Assumes mebm_map.svh supplies the numeric constants.
 */
`default_nettype none

package mebm_pkg;

	typedef enum logic [1:0] {
		MODE_RESET,
		MODE_NORMAL,
		MODE_HOST
	} mebm_mode_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} mebm_pin8_t;

	typedef struct packed {
		logic        req;
		logic        write;
		logic        ptr16;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mebm_xreq_t;

	typedef struct packed {
		mebm_mode_t  mode;
		logic [3:0]  ph;
		logic [4:0]  rst_cnt;
		logic        host_pend;
		logic        ext_fetch;
		logic        data_cyc;
		mebm_xreq_t  xr;
		logic [7:0]  rdata;
		logic        ack;
		logic [7:0]  fetch_data;
		logic        fetch_valid;
		logic        program_store_strobe_n_prev;
		logic [7:0]  host_code;
		logic [7:0]  host_addr;
		logic [15:0] host_ctrl;
	} mebm_state_t;

endpackage : mebm_pkg

`default_nettype wire

// file: src/mebm_top.sv
/*
 * External memory bus strobes, port pin roles and reset/boot-mode
 * selection of an 8-bit microcontroller.
 * Assumes core_clk is the crystal clock and all pin inputs are
 * synchronous to it; pin wires are resolved outside from oe_n.
 */
`default_nettype none

`include "mebm_map.svh"

// Contract
// R1: reset pin high for two machine cycles resets the device.
// R2: strobe pin forced low after 20 reset cycles selects host mode.
// R3: internal execution keeps program store strobe high.
// R4: external fetch pulses strobe twice per cycle, once in data cycles.
// R5: address latch strobe marks low address on port zero each access.
// R6: normal operation emits address latch strobe at crystal/6.
// R7: each external data access omits one address latch pulse.
// R8: inhibit bit set stops the address latch strobe.
// R9: address latch pin is the low-active programming pulse input.
// R10: external access low fetches externally, high internally.
// R11: lock level 4 forces internal execution.
// R12: port two drives high address during fetches and pointer accesses.
// R13: host mode port zero takes code bytes, drives them when verifying.
// R14: host presents low address on port one, control on ports two/three.
// R15: port zero is open drain; a one floats.
// R16: ports one to four are quasi-bidirectional; a one is released.
// R17: port three bits six/seven are write and read strobes.
// R18: machine cycle is 12 clocks, or 6 in fast mode.
// R19: fast mode emits address latch strobe at crystal/3.
// R20: operating mode latched at reset release, kept until next reset.
// R21: inactive strobes are held high.
module mebm_top (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 reset_pin,
	input  wire logic                 six_clock_mode,
	input  wire logic                 address_latch_inhibit,
	input  wire logic                 external_access_n,
	input  wire logic                 lock_level4,
	input  wire logic [15:0]          fetch_addr,
	input  wire mebm_pkg::mebm_xreq_t xreq,
	input  wire logic [7:0]           port0_latch,
	input  wire logic [7:0]           port1_latch,
	input  wire logic [7:0]           port2_latch,
	input  wire logic [7:0]           port3_latch,
	input  wire logic [3:0]           port4_latch,
	input  wire logic                 host_verify,
	input  wire logic [7:0]           host_verify_byte,
	output logic                      xdata_ack,
	output logic [7:0]                xdata_rdata,
	output logic [7:0]                fetch_data,
	output logic                      fetch_valid,
	output logic                      in_reset,
	output logic                      host_mode,
	output logic                      ext_fetch,
	output logic [7:0]                host_code_byte,
	output logic [7:0]                host_addr_low,
	output logic [15:0]               host_ctrl,
	output logic                      programming_pulse_n,
	input  wire logic                 program_store_strobe_n_in,
	output logic                      program_store_strobe_n_out,
	output logic                      program_store_strobe_n_oe_n,
	input  wire logic                 ale_in,
	output logic                      ale_out,
	output logic                      ale_oe_n,
	input  wire logic [7:0]           port_zero_bus_in,
	output mebm_pkg::mebm_pin8_t      port_zero_bus,
	input  wire logic [7:0]           port_one_in,
	output mebm_pkg::mebm_pin8_t      port_one,
	input  wire logic [7:0]           port_two_high_address_in,
	output mebm_pkg::mebm_pin8_t      port_two_high_address,
	input  wire logic [7:0]           port_three_in,
	output mebm_pkg::mebm_pin8_t      port_three,
	output logic [3:0]                port_four_out,
	output logic [3:0]                port_four_oe_n
);
	import mebm_pkg::*;

	localparam mebm_state_t ST_RST = '0;
	localparam mebm_pin8_t PIN_FREE = '{out: `MEBM_BYTE_ZERO, oe_n: `MEBM_BYTE_ONES};

	mebm_state_t st_reg;
	mebm_state_t st_next;
	logic [4:0]  step;
	logic [4:0]  ph_inc;
	logic        half_end;
	logic        mc_end;
	logic        second;
	logic [3:0]  ho;
	logic        ale_win;
	logic        normal;
	logic        dfirst;
	logic        strobe;
	logic        program_store_strobe_n_active;
	mebm_pin8_t  p4;

	// released where the latch holds one, pulled low where zero
	function automatic mebm_pin8_t quasi_drive(input logic [7:0] latch);
		mebm_pin8_t p;
		p.out  = `MEBM_BYTE_ZERO;
		p.oe_n = latch;
		return p;
	endfunction : quasi_drive

	always_comb begin
		st_next = st_reg;
		step = six_clock_mode ? `MEBM_STEP_FAST : `MEBM_STEP_STD; // R18
		ph_inc = {1'b0, st_reg.ph} + step;
		half_end = (ph_inc == `MEBM_PH_HALF);
		mc_end = (ph_inc >= `MEBM_PH_MC);
		st_next.ph = mc_end ? `MEBM_PH_ZERO : ph_inc[3:0];
		st_next.ack = 1'b0;
		st_next.fetch_valid = 1'b0;
		st_next.program_store_strobe_n_prev = program_store_strobe_n_in;
		if (!reset_pin) begin
			st_next.rst_cnt = `MEBM_CNT_ZERO;
		end else if (mc_end && st_reg.rst_cnt != `MEBM_CNT_SAT) begin
			st_next.rst_cnt = st_reg.rst_cnt + `MEBM_CNT_ONE; // R1
		end
		unique case (st_reg.mode)
			MODE_RESET: begin
				// strobe pin is released here so the host can force it
				if (reset_pin && st_reg.rst_cnt > `MEBM_HOST_MC &&
				    st_reg.program_store_strobe_n_prev && !program_store_strobe_n_in) begin
					st_next.host_pend = 1'b1; // R2
				end
				if (!reset_pin) begin
					st_next.mode = st_reg.host_pend ? MODE_HOST : MODE_NORMAL; // R20
					st_next.ext_fetch = !external_access_n && !lock_level4; // R10 R11
				end
			end
			MODE_NORMAL: begin
				if (half_end && st_reg.data_cyc) begin
					st_next.ack = 1'b1;
					if (!st_reg.xr.write) begin
						st_next.rdata = port_zero_bus_in;
					end
				end
				if (st_reg.ext_fetch && (mc_end || (half_end && !st_reg.data_cyc))) begin
					st_next.fetch_data = port_zero_bus_in;
					st_next.fetch_valid = 1'b1;
				end
				// data accesses start only on a machine cycle boundary
				if (mc_end) begin
					st_next.data_cyc = xreq.req;
					st_next.xr = xreq;
				end
			end
			MODE_HOST: begin
				st_next.host_code = port_zero_bus_in; // R13
				st_next.host_addr = port_one_in; // R14
				st_next.host_ctrl = {port_three_in, port_two_high_address_in}; // R14
			end
		endcase
		if (reset_pin && st_reg.rst_cnt >= `MEBM_RST_MC && st_reg.mode != MODE_RESET) begin
			st_next.mode = MODE_RESET; // R1
			st_next.host_pend = 1'b0;
			st_next.data_cyc = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		second = (st_reg.ph >= `MEBM_HALF_OFS);
		ho = second ? st_reg.ph - `MEBM_HALF_OFS : st_reg.ph;
		ale_win = (ho < `MEBM_ALE_LEN);
		normal = (st_reg.mode == MODE_NORMAL);
		dfirst = st_reg.data_cyc && !second;
		strobe = dfirst && !ale_win;
		// the data half replaces one fetch pulse; its own ALE carries the data address
		program_store_strobe_n_active = normal && st_reg.ext_fetch && !ale_win && !dfirst; // R3 R4
	end

	// ALE keeps running even for internal code, usable as a clock
	assign ale_out = normal && ale_win && !address_latch_inhibit &&
	                 !(st_reg.data_cyc && second); // R5 R6 R7 R8 R19
	assign ale_oe_n = !normal;
	assign programming_pulse_n = (st_reg.mode == MODE_HOST) ? ale_in : 1'b1; // R9
	assign program_store_strobe_n_out = !program_store_strobe_n_active; // R21
	assign program_store_strobe_n_oe_n = !normal;

	always_comb begin
		port_zero_bus = PIN_FREE;
		if (st_reg.mode == MODE_HOST) begin
			if (host_verify) begin
				port_zero_bus.oe_n = host_verify_byte; // R13
			end
		end else if (normal && (st_reg.ext_fetch || dfirst)) begin
			if (ale_win) begin
				port_zero_bus.out = dfirst ? st_reg.xr.addr[7:0] : fetch_addr[7:0]; // R5
				port_zero_bus.oe_n = `MEBM_BYTE_ZERO;
			end else if (strobe && st_reg.xr.write) begin
				port_zero_bus.out = st_reg.xr.wdata;
				port_zero_bus.oe_n = `MEBM_BYTE_ZERO;
			end
		end else if (normal) begin
			port_zero_bus = quasi_drive(port0_latch); // R15
		end
	end

	always_comb begin
		port_two_high_address = PIN_FREE;
		if (normal && ((st_reg.ext_fetch && !dfirst) || (dfirst && st_reg.xr.ptr16))) begin
			// driven both ways: strong pull-up on rising address bits
			port_two_high_address.out = dfirst ? st_reg.xr.addr[15:8] : fetch_addr[15:8]; // R12
			port_two_high_address.oe_n = `MEBM_BYTE_ZERO;
		end else if (normal) begin
			port_two_high_address = quasi_drive(port2_latch); // R16
		end
	end

	always_comb begin
		port_three = PIN_FREE;
		port_one = PIN_FREE;
		p4 = PIN_FREE;
		if (normal) begin
			port_one = quasi_drive(port1_latch); // R16
			p4 = quasi_drive({`MEBM_NIB_ONES, port4_latch}); // R16
			port_three = quasi_drive(port3_latch); // R16
			if (dfirst) begin
				port_three.out[6] = !(strobe && st_reg.xr.write); // R17 R21
				port_three.out[7] = !(strobe && !st_reg.xr.write); // R17 R21
				port_three.oe_n[7:6] = 2'b00;
			end
		end
	end

	assign port_four_out = p4.out[3:0];
	assign port_four_oe_n = p4.oe_n[3:0];
	assign xdata_ack = st_reg.ack;
	assign xdata_rdata = st_reg.rdata;
	assign fetch_data = st_reg.fetch_data;
	assign fetch_valid = st_reg.fetch_valid;
	assign in_reset = (st_reg.mode == MODE_RESET);
	assign host_mode = (st_reg.mode == MODE_HOST);
	assign ext_fetch = st_reg.ext_fetch;
	assign host_code_byte = st_reg.host_code;
	assign host_addr_low = st_reg.host_addr;
	assign host_ctrl = st_reg.host_ctrl;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_RST_TWO_MC: assert property ( // R1
		$rose(in_reset) |-> $past(reset_pin) && $past(st_reg.rst_cnt) >= `MEBM_RST_MC)
		else $error("reset entered before two machine cycles");

	AST_HOST_ENTRY: assert property ( // R2
		$rose(host_mode) |-> $past(st_reg.host_pend) && !$past(reset_pin))
		else $error("host mode without forced strobe edge");

	AST_PROGRAM_STORE_STROBE_N_INTERNAL: assert property ( // R3
		normal && !st_reg.ext_fetch |-> program_store_strobe_n_out && !program_store_strobe_n_oe_n)
		else $error("strobe active during internal execution");

	AST_PROGRAM_STORE_STROBE_N_TWICE: assert property ( // R4
		normal && st_reg.ext_fetch && !six_clock_mode && st_reg.ph == `MEBM_PH_ZERO && !st_reg.data_cyc
		&& !reset_pin
		|-> ##2 !program_store_strobe_n_out [*4] ##1 program_store_strobe_n_out [*2]
		##1 !program_store_strobe_n_out [*4])
		else $error("strobe not pulsed twice per cycle");

	AST_ALE_SIXTH: assert property ( // R6
		normal && !address_latch_inhibit && !six_clock_mode && st_reg.ph == `MEBM_PH_ZERO && !st_reg.data_cyc
		&& !reset_pin
		|-> ale_out [*2] ##1 !ale_out [*4] ##1 ale_out [*2])
		else $error("latch strobe not at crystal/6");

	AST_ALE_SKIP: assert property ( // R7
		st_reg.data_cyc && second |-> !ale_out)
		else $error("latch pulse not skipped in data cycle");

	AST_ALE_INHIBIT: assert property ( // R8
		address_latch_inhibit |-> !ale_out)
		else $error("latch strobe while inhibited");

	AST_PROGRAMMING_PULSE_N_PULSE: assert property ( // R9
		host_mode |-> programming_pulse_n == ale_in && ale_oe_n)
		else $error("programming pulse not taken from latch pin");

	AST_FETCH_SOURCE: assert property ( // R11
		$rose(normal) |-> st_reg.ext_fetch == (!$past(external_access_n) && !$past(lock_level4)))
		else $error("fetch source latched wrongly");

	AST_P2_ADDR: assert property ( // R12
		normal && st_reg.ext_fetch && !dfirst |->
		port_two_high_address.out == fetch_addr[15:8] && port_two_high_address.oe_n == `MEBM_BYTE_ZERO)
		else $error("high address not on port two");

	AST_WR_STROBE: assert property ( // R17
		strobe && st_reg.xr.write |-> !port_three.out[6] && port_three.out[7] && port_three.oe_n[7:6] == 2'b00
		&& port_zero_bus.out == st_reg.xr.wdata && port_zero_bus.oe_n == `MEBM_BYTE_ZERO)
		else $error("write strobe wrong");

	AST_ALE_THIRD: assert property ( // R19
		normal && !address_latch_inhibit && six_clock_mode && st_reg.ph == `MEBM_PH_ZERO && !st_reg.data_cyc
		&& !reset_pin
		|-> ale_out ##1 !ale_out [*2] ##1 ale_out)
		else $error("latch strobe not at crystal/3");

	CV_HOST: cover property ($rose(host_mode));
	CV_DATA_ACK: cover property (xdata_ack && !st_reg.xr.write);
	CV_FETCH: cover property (fetch_valid ##6 fetch_valid);
	CV_FAST: cover property (six_clock_mode && ale_out && normal);

endmodule : mebm_top

`default_nettype wire

// file: tb/mebm_top_tb.sv
/* Self-checking bench of the bus strobe and boot-mode block.
   Assumes mebm_xmem answers with a byte derived from its latched address. */
`default_nettype none
module mebm_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mebm_pkg::*;
	logic        core_clk = 1'b0, rst = 1'b1, reset_pin = 1'b0, six_clock_mode = 1'b0;
	logic        address_latch_inhibit = 1'b0, external_access_n = 1'b1, lock_level4 = 1'b0;
	logic        host_verify = 1'b0, program_store_strobe_n_drv = 1'b1, ale_drv = 1'b1, host_en = 1'b0;
	logic [15:0] fetch_addr = 16'h12C3;
	mebm_xreq_t  xreq = '0;
	logic [7:0]  port0_latch = 8'hA5, port1_latch = 8'h5A, port2_latch = 8'hFF, port3_latch = 8'hFF;
	logic [3:0]  port4_latch = 4'h9;
	logic [7:0]  host_verify_byte = 8'h3C, host_byte = 8'h6B, port_one_in = 8'h21;
	logic [7:0]  port_two_high_address_in = 8'h47, port_three_in = 8'hE8;
	logic        xdata_ack, fetch_valid, in_reset, host_mode, ext_fetch, programming_pulse_n;
	logic [7:0]  xdata_rdata, fetch_data, host_code_byte, host_addr_low, mem_out, cap_p2, cap_p0;
	logic [15:0] host_ctrl;
	logic        program_store_strobe_n_out, program_store_strobe_n_oe_n, ale_out, ale_oe_n;
	logic [3:0]  port_four_out, port_four_oe_n;
	mebm_pin8_t  port_zero_bus, port_one, port_two_high_address, port_three;
	logic        program_store_strobe_n_in, ale_in, rd_n, wr_n, ale_prev = 1'b0, program_store_strobe_n_prev = 1'b1, acked;
	logic [7:0]  port_zero_bus_in;
	int          fails = 0, total_checks = 0, n_ale, n_program_store_strobe_n, n_rd, n_wr;

	assign program_store_strobe_n_in = program_store_strobe_n_oe_n ? program_store_strobe_n_drv : program_store_strobe_n_out;
	assign ale_in = ale_oe_n ? ale_drv : ale_out;
	assign rd_n = port_three.oe_n[7] | port_three.out[7];
	assign wr_n = port_three.oe_n[6] | port_three.out[6];
	assign port_zero_bus_in = (port_zero_bus.out & ~port_zero_bus.oe_n)
		| ((host_en ? (host_verify ? 8'hFF : host_byte) : mem_out) & port_zero_bus.oe_n);

	mebm_top i_mebm_top (.core_clk, .rst, .reset_pin, .six_clock_mode, .address_latch_inhibit,
		.external_access_n, .lock_level4, .fetch_addr, .xreq, .port0_latch, .port1_latch, .port2_latch,
		.port3_latch, .port4_latch, .host_verify, .host_verify_byte, .xdata_ack, .xdata_rdata, .fetch_data,
		.fetch_valid, .in_reset, .host_mode, .ext_fetch, .host_code_byte, .host_addr_low, .host_ctrl,
		.programming_pulse_n, .program_store_strobe_n_in, .program_store_strobe_n_out,
		.program_store_strobe_n_oe_n, .ale_in, .ale_out, .ale_oe_n, .port_zero_bus_in, .port_zero_bus,
		.port_one_in, .port_one, .port_two_high_address_in, .port_two_high_address, .port_three_in,
		.port_three, .port_four_out, .port_four_oe_n);

	mebm_xmem i_mebm_xmem (.core_clk, .ale(ale_in), .program_store_strobe_n_n(program_store_strobe_n_in), .rd_n,
		.addr_lo(port_zero_bus_in), .addr_hi(port_two_high_address.out), .bus_out(mem_out));

	always #25 core_clk = ~core_clk;

	// sampled just after the edge so registered pins have settled
	always @(posedge core_clk) begin
		#1;
		if (ale_in && !ale_prev)
			n_ale++;
		if (!program_store_strobe_n_in && program_store_strobe_n_prev)
			n_program_store_strobe_n++;
		if (!rd_n || !wr_n)
			cap_p2 = port_two_high_address.out;
		if (!rd_n)
			n_rd++;
		if (!wr_n) begin
			n_wr++;
			cap_p0 = port_zero_bus.out;
		end
		ale_prev = ale_in;
		program_store_strobe_n_prev = program_store_strobe_n_in;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic run(input int n);
		n_ale = 0;
		n_program_store_strobe_n = 0;
		n_rd = 0;
		n_wr = 0;
		acked = 1'b0;
		repeat (n) begin
			@(negedge core_clk);
			if (xdata_ack === 1'b1) begin
				xreq.req = 1'b0;
				acked = 1'b1;
			end
		end
	endtask : run

	// a host boot holds the reset pin past twenty machine cycles, then forces the strobe low
	task automatic boot(input logic ea, input logic lk, input logic six, input logic host, input logic inh);
		external_access_n = ea;
		lock_level4 = lk;
		reset_pin = 1'b1;
		repeat (36) @(negedge core_clk);
		chk("in_reset", 1, in_reset);
		// cycle length and inhibit change only in reset, where the phase counter keeps running and can be mid-cycle
		six_clock_mode = six;
		address_latch_inhibit = inh;
		repeat (host ? 264 : 12) @(negedge core_clk);
		program_store_strobe_n_drv = !host;
		@(negedge core_clk);
		reset_pin = 1'b0;
		@(negedge core_clk);
		program_store_strobe_n_drv = 1'b1;
		host_en = host;
		external_access_n = !ea;
		@(negedge core_clk);
		chk("host_mode", host, host_mode);
		chk("ext_fetch", !ea && !lk, ext_fetch);
	endtask : boot

	task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d);
		logic last;
		int i;
		last = 1'b1;
		i = 0;
		while (!(ale_in === 1'b1 && !last) && i < 40) begin
			last = ale_in;
			@(negedge core_clk);
			i++;
		end
		if (i == 40) begin
			fails++;
			results();
		end
		xreq = '{1'b1, wr, 1'b1, a, d};
		run(24);
		chk("ale_pulses", 3, n_ale);
		chk("program_store_strobe_n_pulses", 3, n_program_store_strobe_n);
		chk("ack", 1, acked);
		chk("rd_clocks", wr ? 0 : 4, n_rd);
		chk("wr_clocks", wr ? 4 : 0, n_wr);
		chk("high_addr", a[15:8], cap_p2);
		if (wr)
			chk("wdata", d, cap_p0);
		else
			chk("rdata", a[15:8] ^ a[7:0] ^ 8'h5A, xdata_rdata);
	endtask : xfer

	initial begin
		int i;
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		boot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("p0_oe_n", port0_latch, port_zero_bus.oe_n);
		chk("p1_oe_n", port1_latch, port_one.oe_n);
		chk("p4_oe_n", port4_latch, port_four_oe_n);
		run(24);
		chk("ale_pulses", 4, n_ale);
		chk("program_store_strobe_n_pulses", 0, n_program_store_strobe_n);
		chk("idle_strobes", 3'b111, {program_store_strobe_n_in, rd_n, wr_n});
		boot(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		run(24);
		chk("ale_inhibited", 0, n_ale);
		boot(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		boot(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		run(12);
		chk("ale_fast", 4, n_ale);
		boot(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		run(24);
		chk("program_store_strobe_n_pulses", 4, n_program_store_strobe_n);
		chk("ale_pulses", 4, n_ale);
		i = 0;
		while (fetch_valid !== 1'b1 && i < 30) begin
			@(negedge core_clk);
			i++;
		end
		if (i == 30) begin
			fails++;
			results();
		end
		chk("fetch_data", fetch_addr[15:8] ^ fetch_addr[7:0] ^ 8'h5A, fetch_data);
		xfer(1'b0, 16'hA55A, 8'h00);
		xfer(1'b1, 16'h3C96, 8'hC3);
		boot(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		ale_drv = 1'b0;
		@(negedge core_clk);
		chk("programming_pulse_n_pulse", 0, programming_pulse_n);
		ale_drv = 1'b1;
		@(negedge core_clk);
		chk("programming_pulse_n_pulse", 1, programming_pulse_n);
		chk("host_code", host_byte, host_code_byte);
		chk("host_addr", port_one_in, host_addr_low);
		chk("host_ctrl", {port_three_in, port_two_high_address_in}, host_ctrl);
		host_verify = 1'b1;
		@(negedge core_clk);
		chk("verify_oe_n", host_verify_byte, port_zero_bus.oe_n);
		chk("verify_loop", host_verify_byte, host_code_byte);
		results();
	end
endmodule : mebm_top_tb
`default_nettype wire

// file: tb/mebm_xmem.sv
/* External program and data memory with its address latch.
   Assumes the bench resolves the port zero and strobe pins. */
`default_nettype none
module mebm_xmem (
	input  wire logic       core_clk,
	input  wire logic       ale,
	input  wire logic       program_store_strobe_n_n,
	input  wire logic       rd_n,
	input  wire logic [7:0] addr_lo,
	input  wire logic [7:0] addr_hi,
	output logic [7:0]      bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] addr_reg = 16'h0000;
	logic [7:0]  last_reg = 8'h00;
	always_ff @(posedge core_clk) begin
		if (ale)
			addr_reg <= {addr_hi, addr_lo};
		if (!program_store_strobe_n_n || !rd_n)
			last_reg <= bus_out;
	end
	// no pull-ups on port zero: a released bus must not look like held data
	always_comb begin
		if (!program_store_strobe_n_n || !rd_n)
			bus_out = addr_reg[15:8] ^ addr_reg[7:0] ^ 8'h5A;
		else
			bus_out = ~last_reg;
	end
endmodule : mebm_xmem
`default_nettype wire
